// ==== core/lcg2_input_select.sv ====
// gate-2 input select stage with its apb register
// assumes data inputs come from muxes already on pclk; apb on pclk
`timescale 1ns/1ns

// Operation
// - bit7 true, bit6 inverted fourth input
// - bit5 passes true third input
// - bit4 passes inverted third input
// - bit3 passes true second input
// - bit2 passes inverted second input
module lcg2_input_select (
    input  wire logic                     pclk,      // core clock
    input  wire logic                     presetn,   // async reset, low
    input  wire lcg2_pkg::lcg2_apb_req_t  apb_req,   // apb request
    output lcg2_pkg::lcg2_apb_rsp_t       apb_rsp,   // apb answer
    input  wire logic [3:0]               data_in,   // inputs 4..1 true
    output logic [7:0]                    gate2_terms // gated terms
);
    import lcg2_pkg::*;

    logic [7:0]  sel_reg;
    logic [7:0]  sel_next;
    logic [7:0]  terms_reg;
    logic [7:0]  terms_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic        ready_reg;
    logic        err_reg;
    logic [3:0]  t_true;
    logic [3:0]  t_inv;
    logic        ready_next;
    logic        err_next;
    logic        access_w;

    // transfer phase as seen by this slave
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_ACCESS
    } lcg2_phase_t;

    lcg2_phase_t phase_reg;
    lcg2_phase_t phase_next;

    // named select fields, one per gated term
    wire g2_in4_true_sel = sel_reg[LCG2_IN4_T_POS];
    wire g2_in4_inv_sel  = sel_reg[LCG2_IN4_N_POS];
    wire g2_in3_true_sel = sel_reg[LCG2_IN3_T_POS];
    wire g2_in3_inv_sel  = sel_reg[LCG2_IN3_N_POS];
    wire g2_in2_true_sel = sel_reg[LCG2_IN2_T_POS];
    wire g2_in2_inv_sel  = sel_reg[LCG2_IN2_N_POS];
    wire g2_in1_true_sel = sel_reg[LCG2_IN1_T_POS];
    wire g2_in1_inv_sel  = sel_reg[LCG2_IN1_N_POS];

    // data inputs under their term names; inverted forms made per term
    wire fourth_input_true = data_in[3];
    wire third_input_true  = data_in[2];
    wire second_input_true = data_in[1];
    wire first_input_true  = data_in[0];

    // decode: setup phase of a transfer to our word
    wire setup_w  = apb_req.psel & ~apb_req.penable;
    wire hit_w    = (apb_req.paddr == LCG2_SEL_OFFSET);
    // write only in our own access cycle, so a stray penable is harmless
    wire wr_w     = apb_req.psel & apb_req.penable & access_w
                    & apb_req.pwrite & hit_w;

    // answer decode: access follows every setup, error if unmapped
    assign access_w   = (phase_reg == PH_ACCESS);
    assign ready_next = (phase_next == PH_ACCESS);
    assign err_next   = setup_w & ~hit_w;

    assign sel_next   = wr_w ? apb_req.pwdata[7:0] : sel_reg;
    // read data latched at setup; upper bits read as zero
    assign rdata_next = (setup_w & hit_w) ? {24'h000000, sel_reg}
                                          : 32'h00000000;

    // fourth input: upper bit pair of the select register
    lcg2_term u_term_in4 (
        .din       (fourth_input_true),
        .sel_true  (g2_in4_true_sel),
        .sel_inv   (g2_in4_inv_sel),
        .term_true (t_true[3]),
        .term_inv  (t_inv[3])
    );

    // third input: true and inverted selected independently
    lcg2_term u_term_in3 (
        .din       (third_input_true),
        .sel_true  (g2_in3_true_sel),
        .sel_inv   (g2_in3_inv_sel),
        .term_true (t_true[2]),
        .term_inv  (t_inv[2])
    );

    // second input
    lcg2_term u_term_in2 (
        .din       (second_input_true),
        .sel_true  (g2_in2_true_sel),
        .sel_inv   (g2_in2_inv_sel),
        .term_true (t_true[1]),
        .term_inv  (t_inv[1])
    );

    // first input: lowest bit pair
    lcg2_term u_term_in1 (
        .din       (first_input_true),
        .sel_true  (g2_in1_true_sel),
        .sel_inv   (g2_in1_inv_sel),
        .term_true (t_true[0]),
        .term_inv  (t_inv[0])
    );

    // pack terms back in register bit order
    assign terms_next[LCG2_IN4_T_POS] = t_true[3];
    assign terms_next[LCG2_IN4_N_POS] = t_inv[3];
    assign terms_next[LCG2_IN3_T_POS] = t_true[2];
    assign terms_next[LCG2_IN3_N_POS] = t_inv[2];
    assign terms_next[LCG2_IN2_T_POS] = t_true[1];
    assign terms_next[LCG2_IN2_N_POS] = t_inv[1];
    assign terms_next[LCG2_IN1_T_POS] = t_true[0];
    assign terms_next[LCG2_IN1_N_POS] = t_inv[0];

    // select register; undefined power-up value replaced by zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_reg <= LCG2_SEL_RESET;
        end else begin
            sel_reg <= sel_next;
        end
    end

    // registered terms so the output comes from a flip-flop,
    // costing one cycle of latency toward the gate logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            terms_reg <= 8'h00;
        end else begin
            terms_reg <= terms_next;
        end
    end

    // phase tracking: setup moves to access, access ends unless a new setup is seen
    always_comb begin
        phase_next = phase_reg;
        case (phase_reg)
            PH_IDLE: begin
                if (setup_w) begin
                    phase_next = PH_ACCESS;
                end
            end
            PH_ACCESS: begin
                // no wait states; access lasts one cycle unless setup is seen again
                phase_next = setup_w ? PH_ACCESS : PH_IDLE;
            end
            default: begin
                phase_next = PH_IDLE;
            end
        endcase
    end

    // phase register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_reg <= PH_IDLE;
        end else begin
            phase_reg <= phase_next;
        end
    end

    // apb ready: one cycle after setup, i.e. no wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_reg <= 1'b0;
        end else begin
            ready_reg <= ready_next;
        end
    end

    // error flag; unmapped words would otherwise fail silently
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_reg <= 1'b0;
        end else begin
            err_reg <= err_next;
        end
    end

    // read data captured at setup, valid with ready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_reg <= 32'h00000000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign apb_rsp.pready  = ready_reg;
    assign apb_rsp.pslverr = err_reg;
    assign apb_rsp.prdata  = rdata_reg;
    assign gate2_terms     = terms_reg;
endmodule

// ==== core/lcg2_pkg.sv ====
// package for the gate-2 input select stage of a logic cell
// assumes an apb slave on a 20 MHz clock, one register word
package lcg2_pkg;
    localparam logic [7:0]  LCG2_SEL_OFFSET = 8'h00; // gate2_input_select
    localparam logic [7:0]  LCG2_SEL_RESET  = 8'h00; // value after reset
    localparam int          LCG2_IN4_T_POS  = 7;
    localparam int          LCG2_IN4_N_POS  = 6;
    localparam int          LCG2_IN3_T_POS  = 5;
    localparam int          LCG2_IN3_N_POS  = 4;
    localparam int          LCG2_IN2_T_POS  = 3;
    localparam int          LCG2_IN2_N_POS  = 2;
    localparam int          LCG2_IN1_T_POS  = 1;
    localparam int          LCG2_IN1_N_POS  = 0;
    localparam int          LCG2_NUM_IN     = 4;

    // apb request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } lcg2_apb_req_t;

    // apb answer to the master
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } lcg2_apb_rsp_t;
endpackage

// ==== core/lcg2_term.sv ====
// one data input's true and inverted term gating for gate 2
// assumes data and selects are synchronous to pclk
`timescale 1ns/1ns
module lcg2_term (
    input  wire logic din,       // data input, true form
    input  wire logic sel_true,  // pass true form
    input  wire logic sel_inv,   // pass inverted form
    output logic      term_true, // gated true term
    output logic      term_inv   // gated inverted term
);
    // a cleared select forces its term to zero (no contribution)
    assign term_true = din & sel_true;
    assign term_inv  = ~din & sel_inv;
endmodule

// ==== tb/lcg2_input_select_checker.sv ====
// checker: gate-2 terms against a shadow of the select register
// assumes a bind into lcg2_input_select, one pclk domain
`timescale 1ns/1ns
module lcg2_input_select_checker (
    input wire logic                    pclk,       // core clock
    input wire logic                    presetn,    // async reset, low
    input wire lcg2_pkg::lcg2_apb_req_t apb_req,    // apb request
    input wire lcg2_pkg::lcg2_apb_rsp_t apb_rsp,    // apb answer
    input wire logic [3:0]              data_in,    // data inputs
    input wire logic [7:0]              gate2_terms // gated terms
);
    import lcg2_pkg::*;
    logic [7:0] s_reg; // design terms lag this by one edge
    wire  [7:0] e = s_reg & {data_in[3], ~data_in[3], data_in[2],
        ~data_in[2], data_in[1], ~data_in[1], data_in[0], ~data_in[0]};
    // shadow write only at the access edge that carries pready
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) s_reg <= LCG2_SEL_RESET;
        else if (apb_req.penable && apb_rsp.pready && apb_req.pwrite &&
                 apb_req.paddr == LCG2_SEL_OFFSET)
            s_reg <= apb_req.pwdata[7:0];
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_d4; gate2_terms[7:6] == $past(e[7:6]); endproperty
    a_d4: assert property (p_d4) else $error("in4 terms");
    property p_d3t; gate2_terms[5] == $past(e[5]); endproperty
    a_d3t: assert property (p_d3t) else $error("in3 true");
    property p_d3n; gate2_terms[4] == $past(e[4]); endproperty
    a_d3n: assert property (p_d3n) else $error("in3 inv");
    property p_d2t; gate2_terms[3] == $past(e[3]); endproperty
    a_d2t: assert property (p_d2t) else $error("in2 true");
    property p_d2n; gate2_terms[2] == $past(e[2]); endproperty
    a_d2n: assert property (p_d2n) else $error("in2 inv");
    property p_d1; gate2_terms[1:0] == $past(e[1:0]); endproperty
    a_d1: assert property (p_d1) else $error("in1 terms");
    // main scenarios: a write, a lit true term, a lit inverted term
    cover property (apb_req.penable && apb_rsp.pready && apb_req.pwrite);
    cover property (gate2_terms[7]);
    cover property (gate2_terms[0]);
endmodule
bind lcg2_input_select lcg2_input_select_checker u_chk (.*);

// ==== tb/lcg2_input_select_tb.sv ====
// bench: apb writes and reads plus data drive for the select stage
// assumes the checker is attached by bind in its own file
`timescale 1ns/1ns
module lcg2_input_select_tb;
    import lcg2_pkg::*;
    logic          pclk = 1'b0, presetn = 1'b0;
    logic [3:0]    data_in = 4'h0;
    logic [7:0]    gate2_terms;
    logic [31:0]   rd, x;
    logic          er;
    lcg2_apb_req_t req = '0;
    lcg2_apb_rsp_t rsp;
    int            n_errors = 0, samples_checked = 0;
    lcg2_input_select dut (.pclk, .presetn, .apb_req(req), .apb_rsp(rsp),
        .data_in, .gate2_terms);
    // free-running 20 MHz clock
    initial forever #25 pclk = ~pclk;
    // held until pready is seen at a rising edge, never a fixed wait
    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk) req <= '{1'b1, 1'b0, w, a, wd};
        @(posedge pclk) req.penable <= 1'b1;
        do @(posedge pclk); while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        er = rsp.pslverr;
        req <= '0;
    endtask
    task chk(input logic [31:0] got, exp);
        samples_checked++;
        if (got !== exp) n_errors++;
        if (got !== exp) $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    endtask
    task test_done;
        $display("checked %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // one-hot select; data lights the term, then the opposite data level leaves it dark
    task t_terms;
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, LCG2_SEL_OFFSET, 32'h1 << (i / 2));
            data_in <= ((i / 2 + i) % 2) ? 4'hF : 4'h0;
            apb(1'b0, LCG2_SEL_OFFSET, 32'h0);
            chk(rd, 32'h1 << (i / 2));
            x = (i % 2) ? 32'h0 : 32'h1 << (i / 2);
            @(negedge pclk);
            chk({24'h0, gate2_terms}, x);
        end
        $display("t_terms done");
    endtask
    // reset value, all true terms lit, then a mid-run reset clears them
    task t_reset;
        apb(1'b0, LCG2_SEL_OFFSET, 32'h0);
        chk(rd, {24'h0, LCG2_SEL_RESET});
        apb(1'b1, LCG2_SEL_OFFSET, 32'hFF);
        data_in <= 4'hF;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk({24'h0, gate2_terms}, 32'hAA);
        @(posedge pclk) presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk({24'h0, gate2_terms}, 32'h0);
        apb(1'b0, LCG2_SEL_OFFSET, 32'h0);
        chk(rd, {24'h0, LCG2_SEL_RESET});
        data_in <= 4'h0;
        $display("t_reset done");
    endtask
    // upper write bits ignored; unmapped word errors, leaves reg alone
    task t_map;
        apb(1'b1, LCG2_SEL_OFFSET, 32'hFFFFFF5A);
        chk({31'h0, er}, 32'h0);
        apb(1'b0, LCG2_SEL_OFFSET, 32'h0);
        chk(rd, 32'h5A);
        apb(1'b1, 8'h04, 32'hFF);
        chk({31'h0, er}, 32'h1);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, LCG2_SEL_OFFSET, 32'h0);
        chk(rd, 32'h5A);
        $display("t_map done");
    endtask
    // reset for six cycles, then the scenarios
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_map;
        t_terms;
        test_done;
    end
    // watchdog far beyond the roughly 130 cycles needed
    initial begin
        #100000 n_errors++;
        test_done;
    end
endmodule
